// ---- rtl/sobp_defines.vh ----
// Constants for the sensor output bit packer: object indices, entry counts,
// broadcast word field positions and unit counts.
// Assumes inclusion by bare name from the design files.
`ifndef SOBP_DEFINES_VH
`define SOBP_DEFINES_VH
`define SOBP_IDX_BYTES 16'h6000
`define SOBP_IDX_WORDS 16'h6100
`define SOBP_BYTE_COUNT 8'h08
`define SOBP_WORD_COUNT 8'h04
`define SOBP_UNITS 30
`define SOBP_VAL_LSB 0
`define SOBP_VAL_MSB 31
`define SOBP_SEL_LSB 32
`define SOBP_SEL_MSB 61
`define SOBP_SUB_COUNT 8'h00
`endif

// ---- rtl/sobp_snapshot.v ----
// Snapshot register for the packed sensor output image.
// Assumes sensor outputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sobp_snapshot #(
  parameter W = 64
) (
  input wire clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire [W-1:0] d, // Image to capture
  output reg [W-1:0] q_r // Captured image
);
  // One register feeds both views so they never disagree
  always @(posedge clk)
  begin
    if (!rst_n)
      q_r <= {W{1'b0}};
    else
      q_r <= d;
  end
endmodule
`default_nettype wire

// ---- rtl/sobp_unit_setting.v ----
// One sensor unit's setting register, loaded by the broadcast decoder.
// Assumes one write strobe per broadcast.
`timescale 1ns/1ps
`default_nettype none
module sobp_unit_setting (
  input wire clk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire we, // Load strobe for this unit
  input wire [31:0] val, // Value to load
  output reg [31:0] q_r, // Stored setting
  output reg upd_r // One-cycle update pulse toward the sensor
);
  // Hold the value; pulse when it changes hands
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      q_r <= 32'h0000_0000;
      upd_r <= 1'b0;
    end
    else
    begin
      upd_r <= we;
      if (we)
        q_r <= val;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sobp_packer.v ----
// Sensor output bit packer: byte and word input views plus broadcast
// multi-unit write decoding.
// Assumes the master reads objects by index/subindex and issues one
// broadcast write per bc_wr pulse; all inputs synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "sobp_defines.vh"
module sobp_packer #(
  parameter UNITS = `SOBP_UNITS
) (
  input wire clk, // System clock, 100 MHz
  input wire rst_n, // Synchronous reset, active low
  input wire [2*UNITS-1:0] sens_out, // Outputs 1,2 per unit, unit1 at bits 1:0
  input wire rd_en, // Object read request
  input wire [15:0] rd_index, // Object index
  input wire [7:0] rd_sub, // Object subindex
  output reg [15:0] rd_data_r, // Read data, low bits used for bytes
  output reg rd_ack_r, // Read answered (one cycle)
  output reg rd_err_r, // Read was to unmapped object or subindex
  input wire bc_wr, // Broadcast word write strobe
  input wire [63:0] bc_data, // Broadcast word
  output wire [32*UNITS-1:0] unit_setting, // Settings, unit1 in low word
  output wire [UNITS-1:0] unit_upd // Update pulses per unit
);
  wire [63:0] snap; // Packed snapshot
  wire [UNITS-1:0] sel; // Selection mask field
  wire [UNITS-1:0] eff_sel; // Mask after broadcast expansion
  wire [31:0] val; // Value field
  wire [UNITS-1:0] wr_unit; // Per-unit write strobes
  genvar g;

  // Image padded to 64 bits; bits above unit 30 read zero
  sobp_snapshot #(.W(64)) u_snap (
    .clk(clk),
    .rst_n(rst_n),
    .d({{(64-2*UNITS){1'b0}}, sens_out}),
    .q_r(snap)
  );

  // Top two bits are never looked at
  assign val = bc_data[`SOBP_VAL_MSB:`SOBP_VAL_LSB];
  assign sel = bc_data[`SOBP_SEL_LSB+UNITS-1:`SOBP_SEL_LSB];
  // Empty mask means everyone; full mask reaches everyone anyway
  assign eff_sel = (sel == {UNITS{1'b0}}) ? {UNITS{1'b1}} : sel;
  assign wr_unit = bc_wr ? eff_sel : {UNITS{1'b0}};

  // One setting register per unit
  generate
    for (g = 0; g < UNITS; g = g + 1)
    begin : g_unit
      sobp_unit_setting u_set (
        .clk(clk),
        .rst_n(rst_n),
        .we(wr_unit[g]),
        .val(val),
        .q_r(unit_setting[32*g+31:32*g]),
        .upd_r(unit_upd[g])
      );
    end
  endgenerate

  // Object read decoder; answer one cycle after request
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data_r <= 16'h0000;
      rd_ack_r <= 1'b0;
      rd_err_r <= 1'b0;
    end
    else
    begin
      rd_ack_r <= rd_en;
      rd_err_r <= 1'b0;
      rd_data_r <= 16'h0000;
      if (rd_en)
      begin
        if (rd_index == `SOBP_IDX_BYTES)
        begin
          if (rd_sub == `SOBP_SUB_COUNT)
            rd_data_r <= {8'h00, `SOBP_BYTE_COUNT};
          else if (rd_sub <= `SOBP_BYTE_COUNT)
            rd_data_r <= {8'h00, snap[8*(rd_sub-8'h01)+:8]};
          else
            rd_err_r <= 1'b1;
        end
        else if (rd_index == `SOBP_IDX_WORDS)
        begin
          if (rd_sub == `SOBP_SUB_COUNT)
            rd_data_r <= {8'h00, `SOBP_WORD_COUNT};
          else if (rd_sub <= `SOBP_WORD_COUNT)
            rd_data_r <= snap[16*(rd_sub-8'h01)+:16];
          else
            rd_err_r <= 1'b1;
        end
        else
          rd_err_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/sobp_packer_assertions.sv ----
// Port checker for the packer: read answers and broadcast fan-out.
// Assumes binding onto sobp_packer.
`timescale 1ns/1ps
`default_nettype none
module sobp_packer_assertions #(parameter UNITS = 30) (
  input wire clk, input wire rst_n, input wire [2*UNITS-1:0] sens_out,
  input wire rd_en, input wire [15:0] rd_index, input wire [7:0] rd_sub,
  input wire [15:0] rd_data_r, input wire rd_ack_r, input wire rd_err_r,
  input wire bc_wr, input wire [63:0] bc_data,
  input wire [32*UNITS-1:0] unit_setting, input wire [UNITS-1:0] unit_upd
);
  // Decoded requests
  wire [UNITS-1:0] msk = bc_data[31+UNITS:32];
  wire rb = rd_en && rd_index == 16'h6000;
  wire rw = rd_en && rd_index == 16'h6100;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_ACK: assert property (rd_en |=> rd_ack_r)
    else $error("no ack");
  AST_BCNT: assert property (rb && rd_sub == 8'h00 |=> rd_data_r == 16'h0008)
    else $error("byte count");
  AST_WCNT: assert property (rw && rd_sub == 8'h00 |=> rd_data_r == 16'h0004)
    else $error("word count");
  AST_B8: assert property (rb && rd_sub == 8'h08 |=>
    rd_data_r == {12'h000, $past(sens_out[2*UNITS-1 -: 4], 2)}) else $error("byte 8");
  AST_W4: assert property (rw && rd_sub == 8'h04 |=>
    rd_data_r == {4'h0, $past(sens_out[2*UNITS-1 -: 12], 2)}) else $error("word 4");
  AST_SEL: assert property (bc_wr && |msk && !(&msk) |=> unit_upd == $past(msk))
    else $error("select");
  AST_ALL: assert property (bc_wr && (msk == 0 || &msk) |=> &unit_upd)
    else $error("all units");
  AST_VAL: assert property (bc_wr && bc_data[32] |=>
    unit_setting[31:0] == $past(bc_data[31:0])) else $error("value");
  cover property (bc_wr && msk == 0);
  cover property (rd_ack_r && rd_err_r);
  cover property (rw && rd_sub == 8'h04);
endmodule
bind sobp_packer sobp_packer_assertions #(.UNITS(UNITS)) chk_i (.*);
`default_nettype wire

// ---- testbench/sobp_master_model.sv ----
// Fieldbus master model issuing object reads.
// Assumes answers one cycle after the request edge.
`timescale 1ns/1ps
`default_nettype none
module sobp_master_model (
  input wire logic clk, input wire logic rd_ack_r, input wire logic rd_err_r,
  input wire logic [15:0] rd_data_r, output logic rd_en,
  output logic [15:0] rd_index, output logic [7:0] rd_sub
);
  initial rd_en = 1'b0;
  // Answer stands one cycle only, so it is taken at once
  task rd(input [15:0] i, input [7:0] s, output [17:0] r);
    @(negedge clk);
    {rd_en, rd_index, rd_sub} = {1'b1, i, s};
    @(negedge clk);
    rd_en = 1'b0;
    r = {rd_ack_r, rd_err_r, rd_data_r};
  endtask
endmodule
`default_nettype wire

// ---- testbench/sobp_packer_tb.sv ----
// Bench for the packer: object reads and broadcast writes.
// Assumes the master model drives the read port.
`timescale 1ns/1ps
`default_nettype none
module sobp_packer_tb;
  localparam [63:0] S = 64'h0ABC_1234_5678_9DEF; // Sensor image
  logic clk = 0, rst_n = 0, bc_wr = 0, rd_en, rd_ack_r, rd_err_r;
  logic [63:0] bc_data = 0;
  logic [15:0] rd_index, rd_data_r;
  logic [7:0] rd_sub;
  logic [959:0] unit_setting;
  logic [29:0] unit_upd;
  logic [17:0] r;
  int num_errors = 0, n_checks = 0, k;
  sobp_packer dut (.*, .sens_out(S[59:0]));
  sobp_master_model m (.*);
  always #5 clk = ~clk;
  task chk(input [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bc(input [63:0] w, input [29:0] u);
    @(negedge clk);
    {bc_wr, bc_data} = {1'b1, w};
    @(negedge clk);
    bc_wr = 0;
    chk(unit_upd, u);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  initial begin
    #20000;
    num_errors++;
    close_out;
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    m.rd(16'h6000, 0, r); chk(r, 18'h20008);
    m.rd(16'h6100, 0, r); chk(r, 18'h20004);
    m.rd(16'h6200, 1, r); chk(r, 18'h30000); // Unmapped object
    for (k = 1; k <= 8; k++) begin
      m.rd(16'h6000, k, r); chk(r, {2'b10, 8'h0, S[8*k-8 +: 8]});
    end
    for (k = 1; k <= 4; k++) begin
      m.rd(16'h6100, k, r); chk(r, {2'b10, S[16*k-16 +: 16]});
    end
    $display("reads done");
    bc(64'h20000201000003E8, 30'h20000201);
    for (k = 0; k < 30; k++)
      chk(unit_setting[32*k +: 32], (k == 0 || k == 9 || k == 29) ? 1000 : 0);
    for (k = 0; k < 60; k++) begin
      if (k % 30 == 0) bc(k ? 64'h3FFFFFFF00000007 : 64'hC000000000000005, '1);
      chk(unit_setting[32*(k%30) +: 32], k < 30 ? 5 : 7);
    end
    $display("broadcast done");
    close_out;
  end
endmodule
`default_nettype wire
